// ===== include/fpec_pkg.sv
// How it works
// - start bit launches operation, hardware clears it
// - software sets start bit, never clears
// - operations only while op_enable is one
// - bad start attempt while idle sets sequence error flag
// - erase select picks erase or program variant
// - code 1111 erase is bulk erase, only in serial programming mode
// - code 0011 program writes one word
// - code 0010 erase clears one page
// - code 0001 program writes one row
// - other operation codes never start anything
// - control bits reset only on power-on
// - unimplemented control bits read zero
// - keys 55h then AAh unlock start
// - processor stalls while operation runs
// - page erase covers eight-row block
// - row program writes buffered 64 words
// - key register is write-only
// - table writes stay in holding latches
package fpec_pkg;
  // register byte offsets
  localparam logic [11:0] FPEC_CTRL_OFF = 12'h000;
  localparam logic [11:0] FPEC_KEY_OFF = 12'h004;
  localparam logic [11:0] FPEC_STAT_OFF = 12'h008;
  // control field positions
  localparam int FPEC_START_BIT = 15;
  localparam int FPEC_EN_BIT = 14;
  localparam int FPEC_ERR_BIT = 13;
  localparam int FPEC_ERASE_BIT = 6;
  localparam logic [15:0] FPEC_CTRL_RESET = 16'h0000;
  // unlock keys
  localparam logic [7:0] FPEC_KEY1 = 8'h55;
  localparam logic [7:0] FPEC_KEY2 = 8'haa;
  // operation codes
  localparam logic [3:0] FPEC_OP_BULK = 4'hf;
  localparam logic [3:0] FPEC_OP_WORD = 4'h3;
  localparam logic [3:0] FPEC_OP_PAGE = 4'h2;
  localparam logic [3:0] FPEC_OP_ROW = 4'h1;
  // array geometry
  localparam int FPEC_ROW_WORDS = 64;
  localparam int FPEC_PAGE_WORDS = 512;
  // operation times in microseconds and cycles at 20 MHz
  localparam int FPEC_CLK_MHZ = 20;
  localparam int FPEC_WORD_US = 20;
  localparam int FPEC_ROW_US = 2000;
  localparam int FPEC_PAGE_US = 20000;
  localparam int FPEC_BULK_US = 40000;
  localparam int FPEC_WORD_CYC = FPEC_WORD_US * FPEC_CLK_MHZ;
  localparam int FPEC_ROW_CYC = FPEC_ROW_US * FPEC_CLK_MHZ;
  localparam int FPEC_PAGE_CYC = FPEC_PAGE_US * FPEC_CLK_MHZ;
  localparam int FPEC_BULK_CYC = FPEC_BULK_US * FPEC_CLK_MHZ;
  // kind of array operation
  typedef enum logic [2:0] {FPEC_KIND_NONE, FPEC_KIND_WORD, FPEC_KIND_ROW, FPEC_KIND_PAGE, FPEC_KIND_BULK}
    fpec_kind_t;
endpackage

// ===== core/fpec_unlock.sv
`timescale 1ns/1ns
module fpec_unlock (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // key writes and other writes
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic other_wr,
  input wire logic consume,
  // unlock state
  output logic unlocked
);
  logic half_q;
  logic unlocked_q;

  // two-step key tracker, any stray write drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 1'b0;
      unlocked_q <= 1'b0;
    end else if (key_wr) begin
      half_q <= (key_data == fpec_pkg::FPEC_KEY1);
      unlocked_q <= half_q && (key_data == fpec_pkg::FPEC_KEY2);
    end else if (other_wr || consume) begin
      half_q <= 1'b0;
      unlocked_q <= 1'b0;
    end
  end

  assign unlocked = unlocked_q;
endmodule

// ===== core/fpec_timer.sv
`timescale 1ns/1ns
module fpec_timer #(
  parameter int WORD_CYC = 400,
  parameter int ROW_CYC = 40000,
  parameter int PAGE_CYC = 400000,
  parameter int BULK_CYC = 800000
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // launch
  input wire logic launch,
  input wire fpec_pkg::fpec_kind_t kind,
  // progress
  output logic busy,
  output logic done
);
  logic [19:0] cnt_q;
  logic busy_q;
  logic done_q;

  // cycles for each kind of operation
  function automatic logic [19:0] fpec_len(input fpec_pkg::fpec_kind_t k);
    case (k)
      fpec_pkg::FPEC_KIND_WORD: fpec_len = 20'(WORD_CYC);
      fpec_pkg::FPEC_KIND_ROW: fpec_len = 20'(ROW_CYC);
      fpec_pkg::FPEC_KIND_PAGE: fpec_len = 20'(PAGE_CYC);
      fpec_pkg::FPEC_KIND_BULK: fpec_len = 20'(BULK_CYC);
      default: fpec_len = 20'h00001;
    endcase
  endfunction

  // self-timed countdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 20'h00000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (launch && !busy_q) begin
        cnt_q <= fpec_len(kind);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == 20'h00001) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        cnt_q <= cnt_q - 20'h00001;
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;
endmodule

// ===== core/fpec_ctrl.sv
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module fpec_ctrl #(
  parameter int WORD_CYC = fpec_pkg::FPEC_WORD_CYC,
  parameter int ROW_CYC = fpec_pkg::FPEC_ROW_CYC,
  parameter int PAGE_CYC = fpec_pkg::FPEC_PAGE_CYC,
  parameter int BULK_CYC = fpec_pkg::FPEC_BULK_CYC
) (
  // clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial programming mode strap
  input wire logic serial_prog_mode,
  // array and cpu side
  output logic cpu_stall,
  output logic word_prog,
  output logic row_prog,
  output logic page_erase,
  output logic bulk_erase
);
  logic [15:0] ctrl_rd;
  logic start_q;
  logic en_q;
  logic err_q;
  logic erase_q;
  logic [3:0] op_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [2:0] mode_sync_q;
  logic mode_q;
  logic stall_q;
  logic word_q;
  logic row_q;
  logic page_q;
  logic bulk_q;
  logic [2:0] done_cnt_q;
  logic setup;
  logic acc;
  logic wr_ctrl;
  logic wr_key;
  logic wr_other;
  logic set_try;
  logic unlocked;
  logic launch;
  logic t_busy;
  logic t_done;
  fpec_pkg::fpec_kind_t kind;

  // decode operation from select and code
  function automatic fpec_pkg::fpec_kind_t fpec_decode(input logic er, input logic [3:0] op, input logic ser);
    fpec_decode = fpec_pkg::FPEC_KIND_NONE;
    if (!er && op == fpec_pkg::FPEC_OP_WORD)
      fpec_decode = fpec_pkg::FPEC_KIND_WORD;
    if (!er && op == fpec_pkg::FPEC_OP_ROW)
      fpec_decode = fpec_pkg::FPEC_KIND_ROW;
    if (er && op == fpec_pkg::FPEC_OP_PAGE)
      fpec_decode = fpec_pkg::FPEC_KIND_PAGE;
    if (er && ser && op == fpec_pkg::FPEC_OP_BULK)
      fpec_decode = fpec_pkg::FPEC_KIND_BULK;
  endfunction

  // address map check
  function automatic logic fpec_hit(input logic [11:0] a);
    fpec_hit = (a == fpec_pkg::FPEC_CTRL_OFF) || (a == fpec_pkg::FPEC_KEY_OFF) || (a == fpec_pkg::FPEC_STAT_OFF);
  endfunction

  // bus phases, no wait state, read data registered in the setup cycle
  assign setup = psel && !penable;
  assign acc = psel && penable && pready_q;
  assign wr_ctrl = acc && pwrite && paddr == fpec_pkg::FPEC_CTRL_OFF;
  assign wr_key = acc && pwrite && paddr == fpec_pkg::FPEC_KEY_OFF;
  assign wr_other = acc && pwrite && !wr_key;
  assign set_try = wr_ctrl && pwdata[fpec_pkg::FPEC_START_BIT] && !start_q;
  assign kind = fpec_decode(pwdata[fpec_pkg::FPEC_ERASE_BIT], pwdata[3:0], mode_q);
  // launch only with enable, unlock and a real operation
  assign launch = set_try && pwdata[fpec_pkg::FPEC_EN_BIT] && unlocked
    && kind != fpec_pkg::FPEC_KIND_NONE;

  // control view, unimplemented bits zero
  assign ctrl_rd = {start_q, en_q, err_q, 6'h00, erase_q, 2'h0, op_q};

  // mode strap through three flops, change on agreement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sync_q <= 3'h0;
      mode_q <= 1'b0;
    end else begin
      mode_sync_q <= {mode_sync_q[1:0], serial_prog_mode};
      if (mode_sync_q[1] == mode_sync_q[2])
        mode_q <= mode_sync_q[2];
    end
  end

  // unlock key tracker
  fpec_unlock u_unlock (
    .pclk(pclk),
    .presetn(presetn),
    .key_wr(wr_key),
    .key_data(pwdata[7:0]),
    .other_wr(wr_other),
    .consume(set_try),
    .unlocked(unlocked)
  );

  // self-timed operation length
  fpec_timer #(
    .WORD_CYC(WORD_CYC),
    .ROW_CYC(ROW_CYC),
    .PAGE_CYC(PAGE_CYC),
    .BULK_CYC(BULK_CYC)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .launch(launch),
    .kind(kind),
    .busy(t_busy),
    .done(t_done)
  );

  // start bit: set by launch, cleared only by completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
    end else if (launch) begin
      start_q <= 1'b1;
    end else if (t_done) begin
      start_q <= 1'b0;
    end
  end

  // writable control fields, locked while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      erase_q <= 1'b0;
      op_q <= 4'h0;
    end else if (wr_ctrl && !start_q) begin
      en_q <= pwdata[fpec_pkg::FPEC_EN_BIT];
      erase_q <= pwdata[fpec_pkg::FPEC_ERASE_BIT];
      op_q <= pwdata[3:0];
    end
  end

  // sequence error: a refused start while idle sets, fresh launch clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (set_try && !launch) begin
      err_q <= 1'b1;
    end else if (launch) begin
      err_q <= 1'b0;
    end else if (wr_ctrl && !start_q) begin
      err_q <= pwdata[fpec_pkg::FPEC_ERR_BIT];
    end
  end

  // array strobes held for the whole operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= 1'b0;
      row_q <= 1'b0;
      page_q <= 1'b0;
      bulk_q <= 1'b0;
    end else if (launch) begin
      word_q <= kind == fpec_pkg::FPEC_KIND_WORD;
      row_q <= kind == fpec_pkg::FPEC_KIND_ROW;
      page_q <= kind == fpec_pkg::FPEC_KIND_PAGE;
      bulk_q <= kind == fpec_pkg::FPEC_KIND_BULK;
    end else if (t_done) begin
      word_q <= 1'b0;
      row_q <= 1'b0;
      page_q <= 1'b0;
      bulk_q <= 1'b0;
    end
  end

  // cpu stall from launch until start clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_q <= 1'b0;
    end else begin
      stall_q <= (launch || t_busy) && !t_done;
    end
  end

  // count of completed operations, for status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_cnt_q <= 3'h0;
    end else if (t_done) begin
      done_cnt_q <= done_cnt_q + 3'h1;
    end
  end

  // apb answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !fpec_hit(paddr);
      if (setup && !pwrite) begin
        case (paddr)
          fpec_pkg::FPEC_CTRL_OFF: prdata_q <= {16'h0000, ctrl_rd};
          fpec_pkg::FPEC_STAT_OFF: prdata_q <= {27'h0000000, done_cnt_q, mode_q, t_busy};
          default: prdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // table writes never reach this block; strobes only move latched data
  assign word_prog = word_q;
  assign row_prog = row_q;
  assign page_erase = page_q;
  assign bulk_erase = bulk_q;
  assign cpu_stall = stall_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule

// ===== sim/fpec_props.sv
`timescale 1ns/1ns
module fpec_props #(
  parameter int WORD_CYC = 4,
  parameter int ROW_CYC = 4,
  parameter int PAGE_CYC = 4,
  parameter int BULK_CYC = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // mode and array side
  input wire logic serial_prog_mode,
  input wire logic cpu_stall,
  input wire logic word_prog,
  input wire logic row_prog,
  input wire logic page_erase,
  input wire logic bulk_erase
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a control write of any value, taken this cycle
  wire logic ctrl_wr = psel && penable && pready && pwrite && paddr == fpec_pkg::FPEC_CTRL_OFF;
  wire logic rd_done = psel && penable && pready && !pwrite;
  AST_ONE_STROBE: assert property ($onehot0({word_prog, row_prog, page_erase, bulk_erase}))
    else $error("more than one array operation active");
  AST_STALL_TRACKS: assert property (cpu_stall == (word_prog | row_prog | page_erase | bulk_erase))
    else $error("stall does not match running operation");
  AST_LAUNCH_CAUSE: assert property ($rose(cpu_stall) |-> $past(ctrl_wr && pwdata[15] && pwdata[14]))
    else $error("operation started without an enabled start write");
  AST_STALL_HOLDS: assert property (rd_done && paddr == fpec_pkg::FPEC_CTRL_OFF && $past(cpu_stall) |-> prdata[15])
    else $error("start bit read low while operation runs");
  AST_WORD_CODE: assert property ($rose(word_prog) |-> $past({pwdata[6], pwdata[3:0]}) == 5'h03)
    else $error("word program from wrong code");
  AST_ROW_CODE: assert property ($rose(row_prog) |-> $past({pwdata[6], pwdata[3:0]}) == 5'h01)
    else $error("row program from wrong code");
  AST_PAGE_CODE: assert property ($rose(page_erase) |-> $past({pwdata[6], pwdata[3:0]}) == 5'h12)
    else $error("page erase from wrong code");
  AST_BULK_CODE: assert property ($rose(bulk_erase) |-> serial_prog_mode && $past(pwdata[6] && pwdata[3:0] == 4'hf))
    else $error("bulk erase from wrong code or mode");
  AST_KEY_READ_ZERO: assert property (rd_done && paddr == fpec_pkg::FPEC_KEY_OFF |-> prdata == 32'h0000_0000)
    else $error("key register read not zero");
  AST_CTRL_RSVD: assert property (rd_done && paddr == fpec_pkg::FPEC_CTRL_OFF |-> (prdata & 32'hffff_1fb0) == 32'h0)
    else $error("unimplemented control bits not zero");
  // main scenarios
  cover property ($rose(row_prog));
  cover property ($rose(bulk_erase));
  cover property ($rose(page_erase));
  cover property (pready && pslverr);
endmodule
bind fpec_ctrl fpec_props #(.WORD_CYC(WORD_CYC), .ROW_CYC(ROW_CYC), .PAGE_CYC(PAGE_CYC), .BULK_CYC(BULK_CYC)) u_props (.*);

// ===== sim/tb.sv
`timescale 1ns/1ns
module tb;
  logic pclk, presetn, psel, penable, pwrite, serial_prog_mode, slv_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, cpu_stall, word_prog, row_prog, page_erase, bulk_erase;
  logic [3:0] seen;
  int n_fail, check_count;
  // case table: control value, serial mode, expected strobes, error (2 = not checked)
  logic [15:0] c_val [10] = '{16'hc003, 16'hc001, 16'hc042, 16'hc04f, 16'hc04f, 16'hc043, 16'hc005, 16'h8001,
    16'hc041, 16'hc00f};
  logic c_ser [10] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [3:0] c_stb [10] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
  int c_err [10] = '{0, 0, 0, 0, 1, 1, 1, 1, 1, 1};
  fpec_ctrl #(.WORD_CYC(4), .ROW_CYC(6), .PAGE_CYC(8), .BULK_CYC(10)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_prog_mode(serial_prog_mode), .cpu_stall(cpu_stall),
    .word_prog(word_prog), .row_prog(row_prog), .page_erase(page_erase), .bulk_erase(bulk_erase));
  // clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // closing verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer, released at the edge that takes it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h0, 32'h1);
    rd = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic unlock_start(input logic [15:0] v);
    apb(1'b1, fpec_pkg::FPEC_CTRL_OFF, {16'h0, v & 16'h5fff});
    apb(1'b1, fpec_pkg::FPEC_KEY_OFF, {24'h0, fpec_pkg::FPEC_KEY1});
    apb(1'b1, fpec_pkg::FPEC_KEY_OFF, {24'h0, fpec_pkg::FPEC_KEY2});
    apb(1'b1, fpec_pkg::FPEC_CTRL_OFF, {16'h0, v});
  endtask
  // wait for the end of an operation, gathering strobes
  task automatic wait_done();
    int n;
    n = 0;
    while (cpu_stall === 1'b1 && n < 100) begin
      seen |= {bulk_erase, page_erase, row_prog, word_prog};
      @(posedge pclk);
      n++;
    end
    chk("stall end", {31'h0, cpu_stall}, 32'h0);
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    stop_test();
  end
  initial begin
    {psel, penable, pwrite, serial_prog_mode} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, fpec_pkg::FPEC_CTRL_OFF, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b1, fpec_pkg::FPEC_CTRL_OFF, 32'hffff_5fff);
    apb(1'b0, fpec_pkg::FPEC_CTRL_OFF, 32'h0);
    chk("ctrl unimpl", rd, 32'h0000_404f);
    apb(1'b0, fpec_pkg::FPEC_KEY_OFF, 32'h0);
    chk("key read", rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", {31'h0, slv_err}, 32'h1);
    // the four operation codes, crossed selects, code 0101 and enable off; bulk code with and without serial mode
    for (int i = 0; i < 10; i++) begin
      serial_prog_mode <= c_ser[i];
      repeat (6) @(posedge pclk);
      seen = 4'h0;
      unlock_start(c_val[i]);
      if (c_stb[i] != 4'h0) chk("stall", {31'h0, cpu_stall}, 32'h1);
      wait_done();
      chk("strobes", {28'h0, seen}, {28'h0, c_stb[i]});
      apb(1'b0, fpec_pkg::FPEC_CTRL_OFF, 32'h0);
      chk("start clear", {31'h0, rd[15]}, 32'h0);
      if (c_err[i] != 2) chk("seq err", {31'h0, rd[13]}, c_err[i]);
    end
    // status: four completed operations, serial mode seen, idle
    apb(1'b0, fpec_pkg::FPEC_STAT_OFF, 32'h0);
    chk("status", rd, 32'h0000_0012);
    // software write cannot clear start while running
    unlock_start(16'hc001);
    apb(1'b1, fpec_pkg::FPEC_CTRL_OFF, 32'h0);
    apb(1'b0, fpec_pkg::FPEC_CTRL_OFF, 32'h0);
    chk("start held", rd, 32'h0000_c001);
    wait_done();
    apb(1'b0, fpec_pkg::FPEC_CTRL_OFF, 32'h0);
    chk("after run", rd, 32'h0000_4001);
    // broken unlock: write between keys, then keys reversed
    for (int k = 0; k < 2; k++) begin
      seen = 4'h0;
      apb(1'b1, fpec_pkg::FPEC_KEY_OFF, k ? 32'haa : 32'h55);
      if (k == 0) apb(1'b1, fpec_pkg::FPEC_CTRL_OFF, 32'h4001);
      apb(1'b1, fpec_pkg::FPEC_KEY_OFF, k ? 32'h55 : 32'haa);
      apb(1'b1, fpec_pkg::FPEC_CTRL_OFF, 32'hc001);
      wait_done();
      apb(1'b0, fpec_pkg::FPEC_CTRL_OFF, 32'h0);
      chk("refused", {28'h0, seen}, 32'h0);
      chk("refused err", rd, 32'h0000_6001);
    end
    stop_test();
  end
endmodule
